// *** odfsm_top.sv ***
// Function
// - Pairs 1 to 3 each hold a 28-bit fraction word, reset to zero, whose fraction is twice the word over 2^28.
// - Only pairs 1 to 3 carry a fraction word; pair 0 has none.
// - Setting the sync bit from 0 to 1 holds every PLL-derived divider in reset while it stays 1.
// - Clearing the sync bit from 1 to 0 releases all those dividers in the same cycle.
// - On that release the coarse phase adjustment of each affected output is cleared to zero.
// - The sync bit resets to zero, so dividers run after power-up.
// - Both selectors reset to the PLL code.
`timescale 1ns/1ps
`default_nettype none

module odfsm_top (
    // Clock and reset
    input  wire logic                                      pclk,
    input  wire logic                                      presetn,
    // APB slave
    input  wire logic                                      psel,
    input  wire logic                                      penable,
    input  wire logic                                      pwrite,
    input  wire logic [odfsm_pkg::ADDR_W-1:0]              paddr,
    input  wire logic [31:0]                               pwdata,
    output logic      [31:0]                               prdata,
    output logic                                           pready,
    output logic                                           pslverr,
    // PLL side, same clock domain
    input  wire logic                                      pll_tick,
    input  wire logic [odfsm_pkg::PAIRS-1:0][odfsm_pkg::INT_W-1:0] output_integer_word,
    // Alternate sources, asynchronous pins
    input  wire logic                                      ref_input_zero,
    input  wire logic                                      ref_input_one,
    input  wire logic                                      xtal_input,
    // Outputs
    output logic      [odfsm_pkg::PAIRS-1:0]               clock_output_pair,
    output logic                                           divider_sync_hold,
    output logic                                           phase_adjust_clear
);

    // -------------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------------
    typedef struct packed {
        logic [odfsm_pkg::PAIRS-1:0][31:0]              frac_stage;
        logic [odfsm_pkg::PAIRS-1:0][odfsm_pkg::FRAC_W-1:0] frac_live;
        logic                                           sync_hold;
        logic [odfsm_pkg::SEL_W-1:0]                    sel2;
        logic [odfsm_pkg::SEL_W-1:0]                    sel3;
        logic                                           phase_clr;
        logic [2:0]                                     pin_ff1;
        logic [2:0]                                     pin_ff2;
        logic [odfsm_pkg::PAIRS-1:0]                    pair_out;
        logic [31:0]                                    rdata;
        logic                                           ready;
        logic                                           slverr;
    } odfsm_top_s;

    odfsm_top_s st_reg;
    odfsm_top_s st_next;

    logic [odfsm_pkg::PAIRS-1:0] div_out;

    // -------------------------------------------------------------------------
    // Fraction dividers, one per pair 1 to 3
    // -------------------------------------------------------------------------
    // Pair 0 has its own integer divider elsewhere and no fraction word
    generate
        for (genvar p = 0; p < odfsm_pkg::PAIRS; p++) begin : g_div
            odfsm_div_if dif ();
            // Every divider shares one hold so all restart on the same edge
            assign dif.hold      = st_reg.sync_hold;
            assign dif.tick      = pll_tick;
            assign dif.int_word  = output_integer_word[p];
            assign dif.frac_word = st_reg.frac_live[p];
            assign div_out[p]    = dif.clk_out;

            odfsm_frac_div u_div (
                .pclk    (pclk),
                .presetn (presetn),
                .d       (dif)
            );
        end
    endgenerate

    // -------------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------------
    // Zero-wait APB: answer prepared in setup, taken at the access edge
    always_comb begin
        logic [odfsm_pkg::IDX_W-1:0] idx;
        logic                        setup;
        logic                        wr;
        logic                        hit;
        logic [7:0]                  rbyte;
        logic [7:0]                  wbyte;
        logic [2:0]                  ref_sync;
        logic [odfsm_pkg::SEL_W-1:0] sel;
        idx      = paddr[odfsm_pkg::ADDR_W-1:2];
        setup    = psel & ~penable;
        wr       = psel & penable & st_reg.ready & pwrite;
        hit      = 1'b0;
        rbyte    = 8'h00;
        wbyte    = pwdata[7:0];
        ref_sync = st_reg.pin_ff2;
        sel      = odfsm_pkg::SEL_RST;
        st_next  = st_reg;

        // Pins pass two flip-flops before anything looks at them
        st_next.pin_ff1 = {xtal_input, ref_input_one, ref_input_zero};
        st_next.pin_ff2 = st_reg.pin_ff1;

        // Fraction bytes, most significant first at the lowest index
        for (int p = 0; p < odfsm_pkg::PAIRS; p++) begin
            for (int k = 0; k < 4; k++) begin
                if (idx == odfsm_pkg::IDX_FRAC[p][k]) begin
                    hit   = 1'b1;
                    rbyte = st_reg.frac_stage[p][8*(3-k) +: 8];
                    if (wr) begin
                        st_next.frac_stage[p][8*(3-k) +: 8] = wbyte;
                        // Least significant byte closes the word
                        if (k == 3) begin
                            st_next.frac_live[p] = {st_reg.frac_stage[p][odfsm_pkg::FRAC_W-1:8], wbyte};
                        end
                    end
                end
            end
            // Top nibble of the first byte is reserved; keep it zero
            st_next.frac_stage[p][31:odfsm_pkg::FRAC_W] = '0;
        end

        // Sync and source control
        if (idx == odfsm_pkg::IDX_SYNC_SRC) begin
            hit   = 1'b1;
            rbyte = 8'h00;
            rbyte[odfsm_pkg::SYNC_HOLD_BIT]                    = st_reg.sync_hold;
            rbyte[odfsm_pkg::SEL3_LSB +: odfsm_pkg::SEL_W]     = st_reg.sel3;
            rbyte[odfsm_pkg::SEL2_LSB +: odfsm_pkg::SEL_W]     = st_reg.sel2;
            if (wr) begin
                st_next.sync_hold = pwdata[odfsm_pkg::SYNC_HOLD_BIT];
                st_next.sel3      = pwdata[odfsm_pkg::SEL3_LSB +: odfsm_pkg::SEL_W];
                st_next.sel2      = pwdata[odfsm_pkg::SEL2_LSB +: odfsm_pkg::SEL_W];
            end
        end

        // Spare source registers: mapped, read zero, writes dropped
        if (idx == odfsm_pkg::IDX_SPARE_A || idx == odfsm_pkg::IDX_SPARE_B ||
            idx == odfsm_pkg::IDX_SPARE_C) begin
            hit   = 1'b1;
            rbyte = 8'h00;
        end

        // One-cycle clear of coarse phase on the falling edge of the hold
        st_next.phase_clr = wr && (idx == odfsm_pkg::IDX_SYNC_SRC) &&
                            st_reg.sync_hold && !pwdata[odfsm_pkg::SYNC_HOLD_BIT];

        // Bus answer
        st_next.ready  = setup;
        st_next.slverr = setup & ~hit;
        st_next.rdata  = (setup && !pwrite) ? {24'h000000, rbyte} : 32'h00000000;

        // Output source mux for pairs 2 and 3; pair 1 is always the PLL
        st_next.pair_out[0] = div_out[0];
        for (int p = 1; p < odfsm_pkg::PAIRS; p++) begin
            sel = (p == 1) ? st_reg.sel2 : st_reg.sel3;
            unique case (sel)
                odfsm_pkg::SRC_PLL:  st_next.pair_out[p] = div_out[p];
                odfsm_pkg::SRC_REF0: st_next.pair_out[p] = ref_sync[0];
                odfsm_pkg::SRC_REF1: st_next.pair_out[p] = ref_sync[1];
                odfsm_pkg::SRC_XTAL: st_next.pair_out[p] = ref_sync[2];
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // State register
    // -------------------------------------------------------------------------
    // Dividers run from power-up; both outputs start on the PLL
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg           <= '0;
            st_reg.frac_live <= {odfsm_pkg::PAIRS{odfsm_pkg::FRAC_RST}};
            st_reg.sync_hold <= odfsm_pkg::SYNC_RST;
            st_reg.sel2      <= odfsm_pkg::SEL_RST;
            st_reg.sel3      <= odfsm_pkg::SEL_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // -------------------------------------------------------------------------
    // Outputs, all straight from the state register
    // -------------------------------------------------------------------------
    assign prdata             = st_reg.rdata;
    assign pready             = st_reg.ready;
    assign pslverr            = st_reg.slverr;
    assign clock_output_pair  = st_reg.pair_out;
    assign divider_sync_hold  = st_reg.sync_hold;
    assign phase_adjust_clear = st_reg.phase_clr;

endmodule : odfsm_top

`default_nettype wire

// *** odfsm_pkg.sv ***
`default_nettype none

package odfsm_pkg;

    // -------------------------------------------------------------------------
    // Widths
    // -------------------------------------------------------------------------
    localparam int          FRAC_W      = 28;
    localparam int          INT_W       = 18;
    localparam int          IDX_W       = 10;           // Register index bits
    localparam int          ADDR_W      = IDX_W + 2;    // Byte address = 4 * index
    localparam int          PAIRS       = 3;            // Fractional pairs 1 to 3
    localparam int          SEL_W       = 2;

    // -------------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // -------------------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_FRAC1_B3 = 10'h057;
    localparam logic [IDX_W-1:0] IDX_FRAC1_B2 = 10'h058;
    localparam logic [IDX_W-1:0] IDX_FRAC1_B1 = 10'h059;
    localparam logic [IDX_W-1:0] IDX_FRAC1_B0 = 10'h05A;
    localparam logic [IDX_W-1:0] IDX_FRAC2_B3 = 10'h05B;
    localparam logic [IDX_W-1:0] IDX_FRAC2_B2 = 10'h05C;
    localparam logic [IDX_W-1:0] IDX_FRAC2_B1 = 10'h05D;
    localparam logic [IDX_W-1:0] IDX_FRAC2_B0 = 10'h05E;
    localparam logic [IDX_W-1:0] IDX_FRAC3_B3 = 10'h05F;
    localparam logic [IDX_W-1:0] IDX_FRAC3_B2 = 10'h060;
    localparam logic [IDX_W-1:0] IDX_FRAC3_B1 = 10'h061;
    localparam logic [IDX_W-1:0] IDX_FRAC3_B0 = 10'h062;
    localparam logic [IDX_W-1:0] IDX_SYNC_SRC = 10'h063;
    localparam logic [IDX_W-1:0] IDX_SPARE_A  = 10'h064;
    localparam logic [IDX_W-1:0] IDX_SPARE_B  = 10'h065;
    localparam logic [IDX_W-1:0] IDX_SPARE_C  = 10'h066;

    // Each pair: ordered most significant byte first
    localparam logic [PAIRS-1:0][3:0][IDX_W-1:0] IDX_FRAC = '{
        '{IDX_FRAC3_B0, IDX_FRAC3_B1, IDX_FRAC3_B2, IDX_FRAC3_B3},
        '{IDX_FRAC2_B0, IDX_FRAC2_B1, IDX_FRAC2_B2, IDX_FRAC2_B3},
        '{IDX_FRAC1_B0, IDX_FRAC1_B1, IDX_FRAC1_B2, IDX_FRAC1_B3}};

    // -------------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------------
    localparam int          SYNC_HOLD_BIT = 7;
    localparam int          SEL3_LSB      = 4;
    localparam int          SEL2_LSB      = 0;
    localparam logic [7:0]  FRAC_TOP_MASK = 8'h0F;      // Upper nibble reserved

    // -------------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------------
    localparam logic [FRAC_W-1:0] FRAC_RST = 28'h0000000;
    localparam logic              SYNC_RST = 1'b0;
    localparam logic [SEL_W-1:0]  SEL_RST  = 2'h0;

    // -------------------------------------------------------------------------
    // Source selector codes
    // -------------------------------------------------------------------------
    localparam logic [SEL_W-1:0]  SRC_PLL  = 2'h0;
    localparam logic [SEL_W-1:0]  SRC_REF0 = 2'h1;
    localparam logic [SEL_W-1:0]  SRC_REF1 = 2'h2;
    localparam logic [SEL_W-1:0]  SRC_XTAL = 2'h3;

endpackage : odfsm_pkg

`default_nettype wire

// *** odfsm_div_if.sv ***
`timescale 1ns/1ps
`default_nettype none

// -----------------------------------------------------------------------------
// Control and result of one fractional output divider
// -----------------------------------------------------------------------------
interface odfsm_div_if;
    logic                                hold;
    logic                                tick;
    logic [odfsm_pkg::INT_W-1:0]         int_word;
    logic [odfsm_pkg::FRAC_W-1:0]        frac_word;
    logic                                clk_out;

    modport ctrl (output hold, output tick, output int_word, output frac_word, input clk_out);
    modport div  (input hold, input tick, input int_word, input frac_word, output clk_out);
endinterface : odfsm_div_if

`default_nettype wire

// *** odfsm_frac_div.sv ***
`timescale 1ns/1ps
`default_nettype none

module odfsm_frac_div (
    // Clock and reset
    input  wire logic  pclk,
    input  wire logic  presetn,
    // Divider control
    odfsm_div_if.div   d
);

    // -------------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------------
    typedef struct packed {
        logic [odfsm_pkg::INT_W:0]    cnt;
        logic [odfsm_pkg::FRAC_W-1:0] acc;
        logic                         extra;
        logic                         out;
    } odfsm_div_s;

    odfsm_div_s st_reg;
    odfsm_div_s st_next;

    // Half period is int_word ticks, stretched by one whenever the
    // fraction accumulator carries, so the full ratio is 2*(int + frac/2^28)
    always_comb begin
        logic [odfsm_pkg::FRAC_W:0] sum;
        logic [odfsm_pkg::INT_W:0]  len;
        sum     = {1'b0, st_reg.acc} + {1'b0, d.frac_word};
        len     = {1'b0, d.int_word} + {{odfsm_pkg::INT_W{1'b0}}, st_reg.extra};
        st_next = st_reg;
        if (d.hold) begin
            st_next = '0;
        end else if (d.tick) begin
            if (st_reg.cnt + 19'h00001 >= len) begin
                st_next.cnt   = '0;
                st_next.out   = ~st_reg.out;
                st_next.acc   = sum[odfsm_pkg::FRAC_W-1:0];
                st_next.extra = sum[odfsm_pkg::FRAC_W];
            end else begin
                st_next.cnt = st_reg.cnt + 19'h00001;
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign d.clk_out = st_reg.out;

endmodule : odfsm_frac_div

`default_nettype wire

// *** odfsm_checker.sv ***
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------------------
// Port-level checks of the bus answer and the sync control
// ---------------------------------------------------------------------------
module odfsm_checker (
    // Clock and reset
    input wire logic                           pclk,
    input wire logic                           presetn,
    // APB
    input wire logic                           psel,
    input wire logic                           penable,
    input wire logic                           pwrite,
    input wire logic [odfsm_pkg::ADDR_W-1:0]   paddr,
    input wire logic [31:0]                    pwdata,
    input wire logic [31:0]                    prdata,
    input wire logic                           pready,
    input wire logic                           pslverr,
    // Outputs
    input wire logic [odfsm_pkg::PAIRS-1:0]    clock_output_pair,
    input wire logic                           divider_sync_hold,
    input wire logic                           phase_adjust_clear
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Decoded index and a committed write to the sync register
    logic [odfsm_pkg::IDX_W-1:0] idx;
    logic                        mapped;
    logic                        sync_wr;
    assign idx     = paddr[odfsm_pkg::ADDR_W-1:2];
    assign mapped  = idx >= odfsm_pkg::IDX_FRAC1_B3 && idx <= odfsm_pkg::IDX_SPARE_C;
    assign sync_wr = psel && penable && pwrite && pready && idx == odfsm_pkg::IDX_SYNC_SRC;

    sequence setup_s;   psel && !penable; endsequence
    sequence sync_wr_s; sync_wr;          endsequence

    ready_next_a: assert property (setup_s |=> pready) else $error("no answer after setup");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    slave_err_a: assert property (setup_s |=> pslverr == !mapped) else $error("pslverr wrong for address");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h00000000) else $error("read data outside answer");
    sync_set_a: assert property (sync_wr_s ##0 pwdata[7] |=> divider_sync_hold) else $error("hold not set");
    sync_keep_a: assert property (divider_sync_hold && !sync_wr |=> divider_sync_hold) else $error("hold lost");
    sync_release_a: assert property (sync_wr_s ##0 (divider_sync_hold && !pwdata[7]) |=>
        !divider_sync_hold && phase_adjust_clear) else $error("release or phase clear missing");
    clear_pulse_a: assert property (phase_adjust_clear |=> !phase_adjust_clear) else $error("clear too long");
    clear_cause_a: assert property (phase_adjust_clear |-> $past(divider_sync_hold)) else $error("clear unasked");
    held_quiet_a: assert property (divider_sync_hold [*3] |-> !clock_output_pair[0]) else $error("divider ran");
    reset_out_a: assert property ($rose(presetn) |-> !divider_sync_hold && clock_output_pair == 3'h0)
        else $error("outputs not idle after reset");
endmodule : odfsm_checker

bind odfsm_top odfsm_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .clock_output_pair, .divider_sync_hold, .phase_adjust_clear);

`default_nettype wire

// *** output_divider_fraction_and_source_mux_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module output_divider_fraction_and_source_mux_tb_top;
    // ------------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------------
    logic                                                  pclk, presetn, psel, penable, pwrite;
    logic [odfsm_pkg::ADDR_W-1:0]                          paddr;
    logic [31:0]                                           pwdata, prdata;
    logic                                                  pready, pslverr, pll_tick;
    logic [odfsm_pkg::PAIRS-1:0][odfsm_pkg::INT_W-1:0]     output_integer_word;
    logic                                                  ref_input_zero, ref_input_one, xtal_input;
    logic [odfsm_pkg::PAIRS-1:0]                           clock_output_pair;
    logic                                                  divider_sync_hold, phase_adjust_clear;
    int                                                    miscompares = 0;
    int                                                    n_tests = 0;

    odfsm_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .pll_tick, .output_integer_word, .ref_input_zero, .ref_input_one, .xtal_input,
        .clock_output_pair, .divider_sync_hold, .phase_adjust_clear);

    // ------------------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : results

    // ------------------------------------------------------------------------
    // APB master: entered just after an edge, leaves one edge after release
    // ------------------------------------------------------------------------
    task automatic apb(input logic wr, input logic [odfsm_pkg::IDX_W-1:0] i, input logic [7:0] wd,
                       output logic [7:0] rd, output logic err);
        int n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {i, 2'h0};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            results;
        end
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [odfsm_pkg::IDX_W-1:0] i, input logic [7:0] d);
        logic [7:0] r;
        logic e;
        apb(1'b1, i, d, r, e);
    endtask : wr

    task automatic rchk(input string name, input logic [odfsm_pkg::IDX_W-1:0] i, input logic [7:0] d,
                        input logic er);
        logic [7:0] r;
        logic e;
        apb(1'b0, i, 8'h00, r, e);
        chk(name, d, r);
        chk("pslverr", er, e);
    endtask : rchk

    // Longest spacing between pair 1 toggles; a PLL tick every cycle
    task automatic gap_max(input int cyc, output int mx);
        int g = 0;
        bit seen = 0;
        logic prev = clock_output_pair[0];
        mx = 0;
        repeat (cyc) begin
            @(posedge pclk);
            g++;
            if (clock_output_pair[0] !== prev) begin
                if (seen && g > mx) mx = g;
                seen = 1;
                g = 0;
                prev = clock_output_pair[0];
            end
        end
    endtask : gap_max

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset;
        for (logic [odfsm_pkg::IDX_W-1:0] i = odfsm_pkg::IDX_FRAC1_B3; i <= odfsm_pkg::IDX_SPARE_C; i++)
            rchk("reset value", i, 8'h00, 1'b0);
        chk("hold after reset", 32'h0, divider_sync_hold);
    endtask : t_reset

    task automatic t_errs;
        wr(10'h100, 8'h5A);
        rchk("unmapped read", 10'h100, 8'h00, 1'b1);
        wr(odfsm_pkg::IDX_SPARE_A, 8'h00);
        rchk("spare read", odfsm_pkg::IDX_SPARE_A, 8'h00, 1'b0);
    endtask : t_errs

    task automatic t_sync;
        int mx;
        logic [odfsm_pkg::PAIRS-1:0] frz;
        wr(odfsm_pkg::IDX_SYNC_SRC, 8'h80);
        chk("hold set", 32'h1, divider_sync_hold);
        repeat (3) @(posedge pclk);
        repeat (20) @(posedge pclk) chk("held outputs", 32'h0, clock_output_pair);
        wr(odfsm_pkg::IDX_SYNC_SRC, 8'h00);
        chk("phase clear", 32'h1, phase_adjust_clear);
        // Same ratio on all pairs, so aligned release keeps them equal
        repeat (40) @(posedge pclk) chk("aligned", {3{clock_output_pair[0]}}, clock_output_pair);
        gap_max(40, mx);
        chk("integer spacing", 32'd3, mx);
        // Without PLL ticks the dividers must not step
        pll_tick <= 1'b0;
        repeat (2) @(posedge pclk);
        frz = clock_output_pair;
        repeat (10) @(posedge pclk) chk("no tick frozen", frz, clock_output_pair);
        pll_tick <= 1'b1;
    endtask : t_sync

    task automatic t_commit;
        int mx;
        wr(odfsm_pkg::IDX_FRAC1_B3, 8'h0F);
        wr(odfsm_pkg::IDX_FRAC1_B2, 8'hFF);
        wr(odfsm_pkg::IDX_FRAC1_B1, 8'hFF);
        gap_max(40, mx);
        chk("partial word idle", 32'd3, mx);
        wr(odfsm_pkg::IDX_FRAC1_B0, 8'hFF);
        gap_max(200, mx);
        chk("fraction carry", 32'd4, mx);
        for (int p = 1; p < 3; p++)
            for (int k = 0; k < 4; k++) wr(odfsm_pkg::IDX_FRAC[p][k], 8'h05 + 8'(k * 8'h2B));
        for (int p = 0; p < 3; p++)
            for (int k = 0; k < 4; k++)
                rchk("fraction byte", odfsm_pkg::IDX_FRAC[p][k], p == 0 ? (k == 0 ? 8'h0F : 8'hFF) :
                    8'h05 + 8'(k * 8'h2B), 1'b0);
    endtask : t_commit

    task automatic t_mux;
        logic [1:0] c;
        // Held dividers make the PLL code read as a steady low
        for (int k = 0; k < 4; k++) begin
            c = k[1:0];
            wr(odfsm_pkg::IDX_SYNC_SRC, {2'h2, c, 2'h0, c});
            rchk("select field", odfsm_pkg::IDX_SYNC_SRC, {2'h2, c, 2'h0, c}, 1'b0);
            for (int v = 0; v < 2; v++) begin
                ref_input_zero <= (c == 2'h1) ? v[0] : !v[0];
                ref_input_one <= (c == 2'h2) ? v[0] : !v[0];
                xtal_input <= (c == 2'h3) ? v[0] : !v[0];
                repeat (4) @(posedge pclk);
                chk("mux out", {2{c != 2'h0 && v[0]}}, clock_output_pair[2:1]);
            end
        end
        wr(odfsm_pkg::IDX_SYNC_SRC, 8'h92);
        ref_input_zero <= 1'b1;
        ref_input_one <= 1'b0;
        repeat (4) @(posedge pclk);
        chk("split select", 32'h2, clock_output_pair[2:1]);
    endtask : t_mux

    // ------------------------------------------------------------------------
    // Clock and main sequence
    // ------------------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {ref_input_zero, ref_input_one, xtal_input} = '0;
        pll_tick = 1'b1;
        output_integer_word = {3{18'h00003}};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_errs;
        t_sync;
        t_commit;
        t_mux;
        results;
    end
endmodule : output_divider_fraction_and_source_mux_tb_top

`default_nettype wire
